// ---- rtl/lbc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module lbc_top (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       bus_reset_n_in,
  input  wire logic       core_hold_strap_in,
  input  wire logic       core_reset_clear_in,
  input  wire logic       float_all_strap_in,
  input  wire logic       halted_in,
  input  wire logic       req_valid_in,
  input  wire logic       req_write_in,
  input  wire logic       req_data_in,
  input  wire logic       req_atomic_in,
  input  wire logic [1:0] req_beats_in,
  input  wire logic       bus_request_in,
  input  wire logic       ready_recover_in,
  input  wire logic       use_local_ready_in,
  output logic            req_ready_out,
  output logic            beat_done_out,
  output logic            core_reset_out,
  output logic            clock_stop_out,
  output logic            access_kind_out,
  output logic            access_kind_oe_out,
  output logic            write_read_out,
  output logic            transceiver_direction,
  output logic            data_phase_enable,
  output logic            atomic_lock_n_out,
  output logic            atomic_lock_oe_out,
  output logic            bus_grant_out,
  output logic            ctrl_oe_out,
  output logic            local_ready_recover_out
);
  lbc_pkg::lbc_state_t state;
  lbc_pkg::lbc_state_t next_state;
  logic       kind;
  logic       next_kind;
  logic       wr;
  logic       next_wr;
  logic       den;
  logic       next_den;
  logic       lock_n;
  logic       next_lock_n;
  logic       grant;
  logic       next_grant;
  logic       atomic;
  logic       next_atomic;
  logic       second_half;
  logic       next_second_half;
  logic [1:0] beats;
  logic [1:0] next_beats;
  logic       core_rst;
  logic       next_core_rst;
  logic       floated;
  logic       next_floated;
  logic       bus_rst_d;
  logic       strap_core;
  logic       next_strap_core;
  logic       rdy;
  // Shared state decode and drive permission
  logic       in_idle;
  logic       in_data;
  logic       in_recover;
  logic       drive_ok;

  // Bus pins belong to us only when not floated and not handed over
  function automatic logic lbc_drives(input logic flt, input logic gnt);
    return !flt && !gnt;
  endfunction

  // A pending request takes the bus unless a locked pair is open
  function automatic logic lbc_hold_wins(input logic req,
                                         input logic lck_n);
    return req && lck_n;
  endfunction

  // Access kind pin level from the request's data flag
  function automatic logic lbc_kind_of(input logic is_data);
    return is_data ? lbc_pkg::LBC_KIND_DATA : lbc_pkg::LBC_KIND_CODE;
  endfunction

  // Write/read pin level from the request's write flag
  function automatic logic lbc_wr_of(input logic is_write);
    return is_write ? lbc_pkg::LBC_WR_WRITE : lbc_pkg::LBC_WR_READ;
  endfunction

  // Ready/recover is active low: low means the beat is sampled
  function automatic logic lbc_beat_ok(input logic rdy_level);
    return !rdy_level;
  endfunction

  // Last beat of an access when no extra beats remain
  function automatic logic lbc_last_beat(input logic [1:0] left);
    return left == 2'h0;
  endfunction

  // Closing access of an atomic pair drops the lock
  function automatic logic lbc_pair_ends(input logic is_atomic,
                                         input logic is_second);
    return is_atomic && is_second;
  endfunction

  // One-hot state test, used by several outputs
  function automatic logic lbc_in(input lbc_pkg::lbc_state_t cur,
                                  input lbc_pkg::lbc_state_t want);
    return cur == want;
  endfunction

  // State decode shared by handshakes and the ready generator
  assign in_idle    = lbc_in(state, lbc_pkg::LBC_IDLE);
  assign in_data    = lbc_in(state, lbc_pkg::LBC_DATA);
  assign in_recover = lbc_in(state, lbc_pkg::LBC_RECOVER);
  assign drive_ok   = lbc_drives(floated, grant);

  // Ready source: internal controller or external one
  assign rdy = use_local_ready_in ? local_ready_recover_out
                                  : ready_recover_in;

  // Internal memory controller ready generation
  lbc_ready_gen u_ready (
    .mclk_in                 (mclk_in),
    .rst_n_in                (rst_n_in),
    .data_state_in           (in_data),
    .recover_state_in        (in_recover),
    .local_ready_recover_out (local_ready_recover_out)
  );

  // Float strap capture; only sampled while reset holds
  always_comb begin
    next_floated = floated;
    if (!rst_n_in) begin
      next_floated = !float_all_strap_in;
    end
  end

  // Float mode outlives reset release, so no reset branch here
  always_ff @(posedge mclk_in) begin
    floated <= next_floated;
  end

  // Core hold strap capture and core reset release
  always_comb begin
    next_strap_core = strap_core;
    next_core_rst   = core_rst;
    if (!bus_reset_n_in) begin
      next_strap_core = core_hold_strap_in;
      next_core_rst   = 1'b1;
    end else if (!bus_rst_d) begin
      // First cycle after release: strap decides
      next_core_rst = !strap_core;
    end else if (core_rst && core_reset_clear_in) begin
      next_core_rst = 1'b0;
    end
  end

  // Reset-time capture is clocked, not async, so port levels are legal
  always_ff @(posedge mclk_in) begin
    strap_core <= next_strap_core;
    bus_rst_d  <= bus_reset_n_in;
    core_rst   <= next_core_rst;
  end

  // Bus state machine next values
  always_comb begin
    next_state       = state;
    next_kind        = kind;
    next_wr          = wr;
    next_den         = 1'b0;
    next_lock_n      = lock_n;
    next_grant       = grant;
    next_atomic      = atomic;
    next_second_half = second_half;
    next_beats       = beats;
    case (state)
      // Idle: hold request first, then a new access
      lbc_pkg::LBC_IDLE: begin
        // Request wins over new access unless locked sequence pending
        if (lbc_hold_wins(bus_request_in, lock_n)) begin
          next_state = lbc_pkg::LBC_HOLD;
          next_grant = 1'b1;
        end else if (req_valid_in && !core_rst) begin
          next_state  = lbc_pkg::LBC_ADDR;
          next_kind   = lbc_kind_of(req_data_in);
          next_wr     = lbc_wr_of(req_write_in);
          next_beats  = req_beats_in;
          next_atomic = req_atomic_in;
          if (req_atomic_in && !second_half) begin
            next_lock_n = 1'b0;
          end
        end
      end
      // Address: one cycle, data enable follows
      lbc_pkg::LBC_ADDR: begin
        next_state = lbc_pkg::LBC_DATA;
        next_den   = 1'b1;
      end
      // Data: ready high inserts a wait state
      lbc_pkg::LBC_DATA: begin
        next_den = 1'b1;
        if (lbc_beat_ok(rdy)) begin
          if (lbc_last_beat(beats)) begin
            next_state = lbc_pkg::LBC_RECOVER;
            next_den   = 1'b0;
            if (lbc_pair_ends(atomic, second_half)) begin
              next_lock_n = 1'b1;
            end
            next_second_half = atomic && !second_half;
          end else begin
            next_beats = beats - 2'h1;
          end
        end
      end
      // Recovery: slow parts release the bus before we drive again
      lbc_pkg::LBC_RECOVER: begin
        if (rdy) begin
          next_state = lbc_pkg::LBC_IDLE;
        end
      end
      // Hold: bus handed over until request drops
      lbc_pkg::LBC_HOLD: begin
        if (!bus_request_in) begin
          next_state = lbc_pkg::LBC_IDLE;
          next_grant = 1'b0;
        end
      end
      // Illegal code: recover to idle rather than lock up
      default: begin
        next_state = lbc_pkg::LBC_IDLE;
      end
    endcase
  end

  // Bus state registers; direction follows wr in every phase
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state       <= lbc_pkg::LBC_IDLE;
      kind        <= lbc_pkg::LBC_KIND_DATA;
      wr          <= lbc_pkg::LBC_WR_READ;
      den         <= 1'b0;
      lock_n      <= 1'b1;
      grant       <= 1'b0;
      atomic      <= 1'b0;
      second_half <= 1'b0;
      beats       <= 2'h0;
    end else begin
      state       <= next_state;
      kind        <= next_kind;
      wr          <= next_wr;
      den         <= next_den;
      lock_n      <= next_lock_n;
      grant       <= next_grant;
      atomic      <= next_atomic;
      second_half <= next_second_half;
      beats       <= next_beats;
    end
  end

  // Handshakes toward the access source; refused while held or floated
  assign req_ready_out         = in_idle && !core_rst && !floated
                                 && !lbc_hold_wins(bus_request_in, lock_n);
  assign beat_done_out         = in_data && lbc_beat_ok(rdy);

  // Core and float status
  assign core_reset_out        = core_rst;
  assign clock_stop_out        = floated;

  // Pin levels from flip-flops; data enable inverted, grant masked by float
  assign access_kind_out       = kind;
  assign write_read_out        = wr;
  assign transceiver_direction = wr;
  assign data_phase_enable     = !den;
  assign atomic_lock_n_out     = lock_n;
  assign bus_grant_out         = grant && !floated;

  // Drive enables; floated or held bus stops driving
  assign atomic_lock_oe_out    = drive_ok;
  assign ctrl_oe_out           = drive_ok;
  assign access_kind_oe_out    = drive_ok;
endmodule // lbc_top
`default_nettype wire

// ---- rtl/lbc_pkg.sv ----
package lbc_pkg;
  // Bus state machine encodings, one-hot
  typedef enum logic [5:0] {
    LBC_IDLE    = 6'h01,
    LBC_ADDR    = 6'h02,
    LBC_DATA    = 6'h04,
    LBC_RECOVER = 6'h08,
    LBC_HOLD    = 6'h10,
    LBC_CORE    = 6'h20
  } lbc_state_t;

  // Pin levels
  localparam logic LBC_KIND_CODE   = 1'b0;
  localparam logic LBC_KIND_DATA   = 1'b1;
  localparam logic LBC_DIR_RECEIVE = 1'b0;
  localparam logic LBC_DIR_XMIT    = 1'b1;
  localparam logic LBC_WR_READ     = 1'b0;
  localparam logic LBC_WR_WRITE    = 1'b1;

  // Internal memory controller wait count per data beat
  localparam logic [3:0] LBC_LOCAL_WAITS = 4'h1;
  // Burst length counter width
  localparam int LBC_BEAT_W = 2;
endpackage : lbc_pkg

// ---- rtl/lbc_ready_gen.sv ----
`timescale 1ns/100ps
`default_nettype none
// Local ready/recover generator for the internal memory controller
module lbc_ready_gen (
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  input  wire logic data_state_in,
  input  wire logic recover_state_in,
  output logic      local_ready_recover_out
);
  logic [3:0] wait_cnt;
  logic [3:0] next_wait_cnt;
  logic       next_rdy;

  // Low after fixed waits in data, high in recovery; same meaning as input
  always_comb begin
    next_wait_cnt = wait_cnt;
    next_rdy      = 1'b1;
    if (data_state_in) begin
      if (wait_cnt == lbc_pkg::LBC_LOCAL_WAITS) begin
        next_rdy      = 1'b0;
        next_wait_cnt = 4'h0;
      end else begin
        next_wait_cnt = wait_cnt + 4'h1;
      end
    end else if (recover_state_in) begin
      next_rdy      = 1'b1;
      next_wait_cnt = 4'h0;
    end else begin
      next_wait_cnt = 4'h0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wait_cnt                <= 4'h0;
      local_ready_recover_out <= 1'b1;
    end else begin
      wait_cnt                <= next_wait_cnt;
      local_ready_recover_out <= next_rdy;
    end
  end
endmodule // lbc_ready_gen
`default_nettype wire

// ---- testbench/lbc_mem_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// External memory controller answering data cycles after a set wait count
module lbc_mem_model (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       data_phase_enable,
  input  wire logic [1:0] waits_in,
  output logic            ready_recover_out
);
  logic [1:0] cnt;
  // Reload after each beat so every beat sees its own wait states
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || data_phase_enable || cnt == 2'h0)
      cnt <= waits_in;
    else
      cnt <= cnt - 2'h1;
  end
  // Released high outside data cycles, so recovery can end
  assign ready_recover_out = !(!data_phase_enable && cnt == 2'h0);
endmodule // lbc_mem_model
`default_nettype wire

// ---- testbench/lbc_top_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module lbc_checker (
  input wire logic mclk_in, rst_n_in, req_valid_in, req_ready_out,
  input wire logic bus_request_in, ready_recover_in, use_local_ready_in,
  input wire logic write_read_out, access_kind_out, transceiver_direction,
  input wire logic data_phase_enable, atomic_lock_n_out, bus_grant_out,
  input wire logic ctrl_oe_out, core_reset_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // Taken request, address cycle, then first data cycle
  sequence s_take; req_valid_in && req_ready_out; endsequence
  sequence s_data; ##2 !data_phase_enable; endsequence
  AST_TAKE_TO_DATA: assert property (s_take |-> s_data)
    else $error("data cycle late after take");
  AST_DIR_MATCH: assert property (!data_phase_enable |->
    transceiver_direction == write_read_out)
    else $error("direction differs from write flag");
  AST_DIR_STABLE: assert property (!data_phase_enable &&
    $past(!data_phase_enable) |-> $stable(transceiver_direction))
    else $error("direction moved in data cycle");
  AST_KIND_STABLE: assert property (!data_phase_enable &&
    $past(!data_phase_enable) |->
    $stable({access_kind_out, write_read_out}))
    else $error("kind or write flag moved");
  AST_NO_GRANT_LOCKED: assert property (!atomic_lock_n_out |->
    !bus_grant_out)
    else $error("grant while locked");
  AST_GRANT_FLOATS: assert property (bus_grant_out |-> !ctrl_oe_out)
    else $error("driving while granted");
  AST_GRANT_RELEASE: assert property (bus_grant_out && !bus_request_in
    |=> !bus_grant_out)
    else $error("grant kept after request drop");
  AST_WAIT_STATE: assert property (!data_phase_enable && ready_recover_in
    && !use_local_ready_in |=> !data_phase_enable)
    else $error("no wait state on ready high");
  AST_CORE_HELD: assert property (core_reset_out |-> !req_ready_out)
    else $error("request taken while core held");
endmodule // lbc_checker
bind lbc_top lbc_checker u_chk (.*);
`default_nettype wire

// ---- testbench/local_bus_control_signals_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module local_bus_control_signals_tb;
  logic mclk_in, rst_n_in, bus_reset_n_in, core_hold_strap_in, halted_in;
  logic core_reset_clear_in, float_all_strap_in, req_valid_in, req_write_in;
  logic req_data_in, req_atomic_in, bus_request_in, ready_recover_in;
  logic use_local_ready_in, req_ready_out, beat_done_out, core_reset_out;
  logic clock_stop_out, access_kind_out, access_kind_oe_out, write_read_out;
  logic transceiver_direction, data_phase_enable, atomic_lock_n_out;
  logic atomic_lock_oe_out, bus_grant_out, ctrl_oe_out;
  logic local_ready_recover_out;
  logic [1:0]  req_beats_in, waits;
  logic [31:0] seed = 32'h92f3861c;
  int          err_count, check_count, cyc, nb;
  int          exp_q[$];
  lbc_top dut (.*);
  lbc_mem_model u_mem (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .data_phase_enable(data_phase_enable), .waits_in(waits),
    .ready_recover_out(ready_recover_in));
  // Clock, 40 ns period
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  // Cut a hang short
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string n, logic [3:0] s, logic [3:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset(logic hs, logic fs);
    rst_n_in <= 1'b0;
    bus_reset_n_in <= 1'b0;
    core_hold_strap_in <= hs;
    float_all_strap_in <= fs;
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    bus_reset_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
  endtask
  // One access; held until taken, then beats counted against the requested count
  task automatic acc(logic w, logic d, logic a, logic [1:0] b);
    int n;
    n = 0;
    req_valid_in <= 1'b1;
    req_write_in <= w;
    req_data_in <= d;
    req_atomic_in <= a;
    req_beats_in <= b;
    exp_q.push_back(b + 1);
    @(negedge mclk_in);
    while (req_ready_out !== 1'b1 && n < 100) begin
      @(negedge mclk_in);
      n++;
    end
    @(posedge mclk_in);
    req_valid_in <= 1'b0;
    nb = 0;
    while (nb < b + 1 && n < 300) begin
      @(negedge mclk_in);
      n++;
      if (data_phase_enable === 1'b0) begin
        chk("dir", transceiver_direction, w);
        chk("wr", write_read_out, w);
        chk("kind", access_kind_out, d);
        if (a) chk("lock", atomic_lock_n_out, 1'b0);
      end
      if (beat_done_out === 1'b1 && use_local_ready_in === 1'b1)
        chk("lrdy", local_ready_recover_out, 1'b0);
      if (beat_done_out === 1'b1) nb++;
    end
    chk("beats", nb[3:0], exp_q.pop_front());
    @(posedge mclk_in);
  endtask
  // Main sequence
  initial begin
    logic [31:0] r;
    {rst_n_in, bus_reset_n_in, halted_in, core_reset_clear_in} = 4'h0;
    {req_valid_in, req_write_in, req_data_in, req_atomic_in} = 4'h0;
    {bus_request_in, use_local_ready_in} = 2'h0;
    {core_hold_strap_in, float_all_strap_in} = 2'h3;
    req_beats_in = 2'h0;
    waits = 2'h0;
    do_reset(1'b1, 1'b1);
    chk("core", core_reset_out, 1'b0);
    chk("stop", clock_stop_out, 1'b0);
    for (int i = 0; i < 16; i++) begin
      r = xs();
      waits <= r[1:0];
      use_local_ready_in <= r[2];
      acc(r[3], r[4], 1'b0, r[6:5]);
    end
    use_local_ready_in <= 1'b0;
    acc(1'b0, 1'b1, 1'b1, 2'h0);
    acc(1'b1, 1'b1, 1'b1, 2'h1);
    req_atomic_in <= 1'b0;
    repeat (3) @(negedge mclk_in);
    chk("unlock", atomic_lock_n_out, 1'b1);
    // Hold while running, then while halted
    for (int h = 0; h < 2; h++) begin
      @(posedge mclk_in);
      halted_in <= h[0];
      bus_request_in <= 1'b1;
      repeat (3) @(negedge mclk_in);
      chk("grant", bus_grant_out, 1'b1);
      chk("float", ctrl_oe_out, 1'b0);
      @(posedge mclk_in);
      bus_request_in <= 1'b0;
      repeat (2) @(negedge mclk_in);
      chk("ungrant", bus_grant_out, 1'b0);
    end
    @(posedge mclk_in);
    halted_in <= 1'b0;
    do_reset(1'b0, 1'b1);
    chk("held", core_reset_out, 1'b1);
    chk("refuse", req_ready_out, 1'b0);
    core_reset_clear_in <= 1'b1;
    repeat (3) @(negedge mclk_in);
    chk("freed", core_reset_out, 1'b0);
    @(posedge mclk_in);
    do_reset(1'b1, 1'b0);
    chk("floated", clock_stop_out, 1'b1);
    do_reset(1'b1, 1'b1);
    acc(1'b1, 1'b0, 1'b0, 2'h3);
    finish_test();
  end
endmodule // local_bus_control_signals_tb
`default_nettype wire
